// ---- core/pbcd_pkg.sv ----
// constants, bus carriers and state records of the bus clock divider
package pbcd_pkg;
   localparam int N_BUS = 8;            // bus clock instances
   localparam int DIV_W = 7;            // divisor field width
   localparam int ADDR_W = 8;           // register byte address width
   localparam int BUS_ONE_IDX = 0;      // bus 1, never switched off
   localparam int FAST_BUS_IDX = 6;     // bus 7, full speed after reset
   // register map, one aligned word each
   localparam logic [ADDR_W-1:0] CTRL_BASE = 8'h00;  // bus x at 4*(x-1)
   localparam logic [ADDR_W-1:0] UNLOCK_OFS = 8'h20; // unlock key word
   // field layout of the divisor control word
   localparam int ON_BIT = 15;
   localparam int RDY_BIT = 11;
   localparam int DIV_LSB = 0;
   localparam int UNLOCK_BIT = 0;       // unlocked flag in the key word
   // reset values
   localparam logic ON_RESET = 1'b1;
   localparam logic [DIV_W-1:0] DIV_RESET = 7'h01;      // divide by two
   localparam logic [DIV_W-1:0] DIV_RESET_FAST = 7'h00; // divide by one
   // key pair for the unlock sequence, values arbitrary
   localparam logic [31:0] UNLOCK_KEY1 = 32'h5a5a0001;
   localparam logic [31:0] UNLOCK_KEY2 = 32'ha5a50002;
   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // master to slave side of axi4-lite
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } pbcd_axi_req_s;

   // slave to master side of axi4-lite
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pbcd_axi_rsp_s;

   // one divider channel
   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic [DIV_W-1:0] cur;
      logic [DIV_W-1:0] pend;
      logic busy;
      logic ready;
      logic tick;
   } pbcd_div_s;

   // register file and bus slave
   typedef struct packed {
      logic awready;
      logic wready;
      logic arready;
      logic awHave;
      logic wHave;
      logic [ADDR_W-1:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic keyStage;
      logic unlocked;
      logic [N_BUS-1:0] busOn;
      logic [N_BUS-1:0] divLoad;
      logic [DIV_W-1:0] divVal;
   } pbcd_top_s;
endpackage

// ---- core/pbcd_divider.sv ----
// one bus clock divider channel with hitless ratio change
`timescale 1ns/1ps
module pbcd_divider #(
   parameter int DIV_W = pbcd_pkg::DIV_W,
   parameter logic [pbcd_pkg::DIV_W-1:0] RESET_DIV = pbcd_pkg::DIV_RESET
) (
   input logic sys_clk,
   input logic reset,
   input logic enable,
   input logic loadDiv,
   input logic [pbcd_pkg::DIV_W-1:0] newDiv,
   output logic busClk,
   output logic divReady,
   output logic [pbcd_pkg::DIV_W-1:0] curDiv
);
   // the state record is fixed by the package width
   if (DIV_W != pbcd_pkg::DIV_W)
   begin : g_chk
      $error("divider width must match the package");
   end

   localparam pbcd_pkg::pbcd_div_s RESET_STATE = '{cnt: '0,
      cur: RESET_DIV, pend: RESET_DIV, busy: 1'b0, ready: 1'b1,
      tick: 1'b0};

   pbcd_pkg::pbcd_div_s state_q;  // registered channel state
   pbcd_pkg::pbcd_div_s state_d;  // next channel state

   // next state: count, tick, and switch at a period boundary, or at once while disabled
   always_comb
   begin
      state_d = state_q;
      state_d.tick = 1'b0;
      // change request ignored while busy
      // a request while switching is dropped, the old one stands
      if (loadDiv && !state_q.busy)
      begin
         state_d.pend = newDiv;
         state_d.busy = 1'b1;
      end
      if (!enable)
      begin
         state_d.cnt = '0;
         // nothing runs, so the new ratio may take effect at once
         if (state_q.busy)
         begin
            state_d.cur = state_q.pend;
            state_d.busy = 1'b0;
         end
      end
      else if (state_q.cnt == state_q.cur)
      begin
         state_d.cnt = '0;
         state_d.tick = 1'b1;
         // switch at wrap
         // swapping here keeps every period whole, old or new
         if (state_q.busy)
         begin
            state_d.cur = state_q.pend;
            state_d.busy = 1'b0;
         end
      end
      else
      begin
         state_d.cnt = state_q.cnt + 7'h01;
      end
      state_d.ready = !state_d.busy;
   end

   // state register
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_q <= RESET_STATE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign busClk = state_q.tick;
   assign divReady = state_q.ready;
   assign curDiv = state_q.cur;

   // helper: cycles since the last tick, and the period then in force
   logic [7:0] gap_q;
   logic [DIV_W-1:0] perAt_q;
   logic seen_q;
   always_ff @(posedge sys_clk)
   begin
      if (reset || !enable)
      begin
         seen_q <= 1'b0;
         gap_q <= 8'h00;
         perAt_q <= '0;
      end
      else if (state_q.tick)
      begin
         seen_q <= 1'b1;
         gap_q <= 8'h00;
         perAt_q <= state_q.cur;
      end
      else
      begin
         gap_q <= gap_q + 8'h01;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   a_off_no_tick: assert property (!enable |=> !busClk)
      else $error("bus clock pulsed while disabled");
   a_tick_period: assert property (
      busClk && seen_q && enable |-> gap_q == {1'b0, perAt_q})
      else $error("bus clock period differs from divisor plus one");
   a_ready_return: assert property (
      state_q.busy |-> ##[1:130] divReady)
      else $error("ratio change did not complete in time");
   a_rdy_flag: assert property (loadDiv && divReady |=> !divReady)
      else $error("ready flag stayed high after a ratio change request");
   a_reset_div: assert property ($past(reset) |-> curDiv == RESET_DIV)
      else $error("divisor not at its reset value");
   c_switch: cover property (state_q.busy ##1 !state_q.busy);
   c_slowest: cover property (busClk && seen_q && gap_q == 8'h7f);
endmodule

// ---- core/pbcd_top.sv ----
// eight bus clock dividers behind an axi4-lite register file
// Summary of operation
// - bus clock runs only while enabled
// - ready flag reads one when not switching
// - while switching, ready zero, divisor writes ignored
// - bus clock is system clock over field+1
// - reset divisor two, bus seven divides by one
// - bus one clock can never be disabled
// - control writes accepted only after unlock sequence
// - eight independent divisor registers and dividers
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module pbcd_top #(
   parameter int N_BUS = pbcd_pkg::N_BUS
) (
   input logic sys_clk,
   input logic reset,
   input pbcd_pkg::pbcd_axi_req_s axiReq,
   output pbcd_pkg::pbcd_axi_rsp_s axiRsp,
   output logic [pbcd_pkg::N_BUS-1:0] periphBusClockOut
);
   // the register map and the state record are sized for eight buses
   if (N_BUS != pbcd_pkg::N_BUS)
   begin : g_chk
      $error("bus count must match the register map");
   end

   localparam pbcd_pkg::pbcd_top_s RESET_STATE = '{awready: 1'b1,
      wready: 1'b1, arready: 1'b1, awHave: 1'b0, wHave: 1'b0,
      awAddr: '0, wData: '0, wStrb: '0, bvalid: 1'b0,
      bresp: pbcd_pkg::RESP_OKAY, rvalid: 1'b0, rdata: '0,
      rresp: pbcd_pkg::RESP_OKAY, keyStage: 1'b0, unlocked: 1'b0,
      busOn: {pbcd_pkg::N_BUS{pbcd_pkg::ON_RESET}}, divLoad: '0,
      divVal: '0};

   pbcd_pkg::pbcd_top_s state_q;  // registered slave state
   pbcd_pkg::pbcd_top_s state_d;  // next slave state

   logic [pbcd_pkg::N_BUS-1:0] chanReady;       // per channel ready
   logic [pbcd_pkg::DIV_W-1:0] chanDiv [pbcd_pkg::N_BUS];  // ratio

   // write decode, taken from the held address
   logic wrFire;
   logic wCtrl;
   logic wUnl;
   logic [2:0] wIdx;
   assign wrFire = state_q.awHave && state_q.wHave && !state_q.bvalid;
   assign wCtrl = (state_q.awAddr[7:5] == 3'h0) &&
      (state_q.awAddr[1:0] == 2'h0);
   assign wUnl = (state_q.awAddr == pbcd_pkg::UNLOCK_OFS);
   assign wIdx = state_q.awAddr[4:2];

   // read decode, taken straight from the request
   logic rdFire;
   logic rCtrl;
   logic rUnl;
   logic [2:0] rIdx;
   assign rdFire = axiReq.arvalid && state_q.arready;
   assign rCtrl = (axiReq.araddr[7:5] == 3'h0) &&
      (axiReq.araddr[1:0] == 2'h0);
   assign rUnl = (axiReq.araddr == pbcd_pkg::UNLOCK_OFS);
   assign rIdx = axiReq.araddr[4:2];

   // next state: bus handshakes, register writes, read data
   always_comb
   begin
      state_d = state_q;
      state_d.divLoad = '0;
      // address and data are caught independently, in either order
      if (axiReq.awvalid && state_q.awready)
      begin
         state_d.awAddr = axiReq.awaddr;
         state_d.awHave = 1'b1;
      end
      if (axiReq.wvalid && state_q.wready)
      begin
         state_d.wData = axiReq.wdata;
         state_d.wStrb = axiReq.wstrb;
         state_d.wHave = 1'b1;
      end
      // response taken by the master
      if (state_q.bvalid && axiReq.bready)
      begin
         state_d.bvalid = 1'b0;
      end
      // both halves present: perform the write
      if (wrFire)
      begin
         state_d.awHave = 1'b0;
         state_d.wHave = 1'b0;
         state_d.bvalid = 1'b1;
         state_d.bresp = pbcd_pkg::RESP_OKAY;
         if (wCtrl)
         begin
            // locked writes dropped
            // a locked write still answers okay, it just has no effect
            if (state_q.unlocked)
            begin
               if (state_q.wStrb[pbcd_pkg::ON_BIT/8])
               begin
                  state_d.busOn[wIdx] = state_q.wData[pbcd_pkg::ON_BIT] ||
                     (wIdx == 3'(pbcd_pkg::BUS_ONE_IDX));
               end
               // blocked while switching
               // a load still in flight counts as switching already
               if (state_q.wStrb[0] && chanReady[wIdx] &&
                  !state_q.divLoad[wIdx])
               begin
                  state_d.divLoad[wIdx] = 1'b1;
                  state_d.divVal = state_q.wData[pbcd_pkg::DIV_LSB +:
                     pbcd_pkg::DIV_W];
               end
            end
         end
         else if (wUnl)
         begin
            // unlock sequence
            // first key arms, second key right after it unlocks,
            // anything else locks again
            if (state_q.wData == pbcd_pkg::UNLOCK_KEY1)
            begin
               state_d.keyStage = 1'b1;
            end
            else if (state_q.keyStage &&
               state_q.wData == pbcd_pkg::UNLOCK_KEY2)
            begin
               state_d.keyStage = 1'b0;
               state_d.unlocked = 1'b1;
            end
            else
            begin
               state_d.keyStage = 1'b0;
               state_d.unlocked = 1'b0;
            end
         end
         else
         begin
            // unmapped or unaligned address
            state_d.bresp = pbcd_pkg::RESP_SLVERR;
         end
      end
      // read data taken by the master
      if (state_q.rvalid && axiReq.rready)
      begin
         state_d.rvalid = 1'b0;
      end
      // read: reserved bits return zero
      if (rdFire)
      begin
         state_d.rvalid = 1'b1;
         state_d.rdata = '0;
         state_d.rresp = pbcd_pkg::RESP_OKAY;
         if (rCtrl)
         begin
            state_d.rdata[pbcd_pkg::ON_BIT] = state_q.busOn[rIdx];
            state_d.rdata[pbcd_pkg::RDY_BIT] = chanReady[rIdx] &&
               !state_q.divLoad[rIdx];
            state_d.rdata[pbcd_pkg::DIV_LSB +: pbcd_pkg::DIV_W] =
               chanDiv[rIdx];
         end
         else if (rUnl)
         begin
            state_d.rdata[pbcd_pkg::UNLOCK_BIT] = state_q.unlocked;
         end
         else
         begin
            state_d.rresp = pbcd_pkg::RESP_SLVERR;
         end
      end
      // readies kept registered; one transfer of each kind at a time
      state_d.awready = !state_d.awHave && !state_d.bvalid;
      state_d.wready = !state_d.wHave && !state_d.bvalid;
      state_d.arready = !state_d.rvalid;
   end

   // state register
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_q <= RESET_STATE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign axiRsp = '{awready: state_q.awready, wready: state_q.wready,
      bvalid: state_q.bvalid, bresp: state_q.bresp,
      arready: state_q.arready, rvalid: state_q.rvalid,
      rdata: state_q.rdata, rresp: state_q.rresp};

   for (genvar i = 0; i < pbcd_pkg::N_BUS; i++)
   begin : g_bus
      pbcd_divider #(
         .DIV_W(pbcd_pkg::DIV_W),
         .RESET_DIV((i == pbcd_pkg::FAST_BUS_IDX) ?
            pbcd_pkg::DIV_RESET_FAST : pbcd_pkg::DIV_RESET)
      ) u_div (
         .sys_clk(sys_clk),
         .reset(reset),
         .enable(state_q.busOn[i]),
         .loadDiv(state_q.divLoad[i]),
         .newDiv(state_q.divVal),
         .busClk(periphBusClockOut[i]),
         .divReady(chanReady[i]),
         .curDiv(chanDiv[i])
      );
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   a_bus_one_on: assert property (
      state_q.busOn[pbcd_pkg::BUS_ONE_IDX])
      else $error("bus one clock was switched off");
   a_locked_ignored: assert property (
      wrFire && wCtrl && !state_q.unlocked |=>
      state_q.divLoad == '0 && $stable(state_q.busOn))
      else $error("locked write changed a divisor register");
   a_busy_ignored: assert property (
      wrFire && wCtrl && !chanReady[wIdx] |=> state_q.divLoad == '0)
      else $error("divisor write taken while switching");
   a_div_taken: assert property (
      wrFire && wCtrl && state_q.unlocked && state_q.wStrb[0] &&
      chanReady[wIdx] && !state_q.divLoad[wIdx] |=>
      $onehot(state_q.divLoad) ##1 !(&chanReady))
      else $error("accepted divisor write did not start a switch");
   a_bresp_hold: assert property (
      axiRsp.bvalid && !axiReq.bready |=>
      axiRsp.bvalid && $stable(axiRsp.bresp))
      else $error("write response dropped before it was taken");
   a_rdata_hold: assert property (
      axiRsp.rvalid && !axiReq.rready |=>
      axiRsp.rvalid && $stable(axiRsp.rdata))
      else $error("read data changed before it was taken");
   c_unlock: cover property (!state_q.unlocked ##1 state_q.unlocked);
   c_div_load: cover property (state_q.divLoad != '0);
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the eight-way bus clock divider
`timescale 1ns/1ps
module tb_top;
   logic sys_clk;
   logic reset;
   pbcd_pkg::pbcd_axi_req_s axiReq; // bench is the bus master
   pbcd_pkg::pbcd_axi_rsp_s axiRsp;
   logic [pbcd_pkg::N_BUS-1:0] busClk; // one enable pulse per period
   int miscompares;
   int samples_checked;
   logic [31:0] rdVal;
   logic [1:0] resp;

   pbcd_top pbcd_top_i
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .axiReq(axiReq),
      .axiRsp(axiRsp),
      .periphBusClockOut(busClk)
   );

   // free running 50 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // compare one 32-bit result, four-state exact
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done;
      if (miscompares == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // byte address of the control word of bus index i
   function automatic logic [7:0] ctl(input int i);
      return pbcd_pkg::CTRL_BASE + 8'(4 * i);
   endfunction

   // one axi4-lite write; address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      @(posedge sys_clk);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= d;
      axiReq.wstrb <= s;
      axiReq.bready <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (axiReq.awvalid && axiRsp.awready)
            axiReq.awvalid <= 1'b0;
         if (axiReq.wvalid && axiRsp.wready)
            axiReq.wvalid <= 1'b0;
         if (axiRsp.bvalid)
         begin
            r = axiRsp.bresp;
            axiReq.bready <= 1'b0;
            break;
         end
      end
   endtask

   // one axi4-lite read; rready held until the answer edge
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] r);
      @(posedge sys_clk);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (axiReq.arvalid && axiRsp.arready)
            axiReq.arvalid <= 1'b0;
         if (axiRsp.rvalid)
         begin
            v = axiRsp.rdata;
            r = axiRsp.rresp;
            axiReq.rready <= 1'b0;
            break;
         end
      end
   endtask

   // poll until the ready flag is back; a switch lasts at most 129 cycles
   // and one read takes three edges, so 50 polls cover the slowest ratio
   task automatic wait_rdy(input int i, output logic [31:0] v);
      repeat (50)
      begin
         rd(ctl(i), v, resp);
         if (v[pbcd_pkg::RDY_BIT] === 1'b1)
            break;
      end
   endtask

   // cycles between two consecutive pulses of bus index i
   task automatic period(input int i, input int exp);
      int n;
      n = 0;
      while (busClk[i] !== 1'b1 && n < 300)
      begin
         @(posedge sys_clk);
         n++;
      end
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (busClk[i] !== 1'b1 && n < 300);
      chk("bus period", 32'(exp), 32'(n));
   endtask

   task automatic t_reset;
      logic [31:0] ex;
      for (int i = 0; i < pbcd_pkg::N_BUS; i++)
      begin
         rd(ctl(i), rdVal, resp);
         ex = (i == pbcd_pkg::FAST_BUS_IDX) ? 32'h8800 : 32'h8801;
         chk("reset ctrl", ex, rdVal);
      end
      period(pbcd_pkg::FAST_BUS_IDX, 1);
      period(0, 2);
   endtask

   // locked writes are dropped, then the key pair opens the lock
   task automatic t_lock;
      wr(ctl(1), 32'h8805, 4'h3, resp);
      chk("locked resp", 32'(pbcd_pkg::RESP_OKAY), 32'(resp));
      rd(ctl(1), rdVal, resp);
      chk("locked write", 32'h8801, rdVal);
      wr(pbcd_pkg::UNLOCK_OFS, pbcd_pkg::UNLOCK_KEY1, 4'hf, resp);
      wr(pbcd_pkg::UNLOCK_OFS, pbcd_pkg::UNLOCK_KEY2, 4'hf, resp);
      rd(pbcd_pkg::UNLOCK_OFS, rdVal, resp);
      chk("unlock flag", 32'h1, rdVal);
   endtask

   // each bus gets its own ratio; all eight must differ
   task automatic t_each;
      for (int i = 0; i < pbcd_pkg::N_BUS; i++)
         wr(ctl(i), 32'h8000 | 32'(i), 4'h3, resp);
      for (int i = 0; i < pbcd_pkg::N_BUS; i++)
      begin
         wait_rdy(i, rdVal);
         chk("new divisor", 32'h8800 | 32'(i), rdVal);
         period(i, i + 1);
      end
   endtask

   // slowest ratio, then a switch back with a write during the switch
   task automatic t_switch;
      wr(ctl(2), 32'h807f, 4'h3, resp);
      wait_rdy(2, rdVal);
      period(2, 128);
      wr(ctl(2), 32'h8000, 4'h3, resp);
      rd(ctl(2), rdVal, resp);
      chk("ready mid switch", 32'h0, 32'(rdVal[pbcd_pkg::RDY_BIT]));
      wr(ctl(2), 32'h8005, 4'h3, resp);
      wait_rdy(2, rdVal);
      chk("blocked divisor", 32'h8800, rdVal);
      period(2, 1);
   endtask

   // bus one stays on; bus two goes quiet while disabled
   task automatic t_enable;
      int n;
      wr(ctl(0), 32'h0, 4'h2, resp);
      rd(ctl(0), rdVal, resp);
      chk("bus one enable", 32'h8800, rdVal);
      period(0, 1);
      wr(ctl(1), 32'h0, 4'h2, resp);
      rd(ctl(1), rdVal, resp);
      chk("disabled ctrl", 32'h0801, rdVal);
      n = 0;
      repeat (200)
      begin
         @(posedge sys_clk);
         n += int'(busClk[1] !== 1'b0);
      end
      chk("pulses while off", 32'h0, 32'(n));
      wr(ctl(1), 32'h8000, 4'h2, resp);
      period(1, 2);
   endtask

   // any other key word closes the lock again; holes answer an error
   task automatic t_relock;
      wr(pbcd_pkg::UNLOCK_OFS, 32'h0, 4'hf, resp);
      wr(ctl(3), 32'h8809, 4'h3, resp);
      rd(ctl(3), rdVal, resp);
      chk("relocked write", 32'h8803, rdVal);
      rd(8'h40, rdVal, resp);
      chk("unmapped read", 32'(pbcd_pkg::RESP_SLVERR), 32'(resp));
      wr(8'h44, 32'h1, 4'hf, resp);
      chk("unmapped write", 32'(pbcd_pkg::RESP_SLVERR), 32'(resp));
   endtask

   // main sequence: 16-cycle reset, then the scenarios
   initial
   begin
      axiReq = '0;
      reset = 1'b1;
      miscompares = 0;
      samples_checked = 0;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_lock();
      t_each();
      t_switch();
      t_enable();
      t_relock();
      test_done();
   end

   // hang guard, well above the thousand or so cycles the run needs
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      miscompares++;
      test_done();
   end
endmodule
